// ===== hw/fasc_top.sv
// Fan 3 automatic speed control: register file, source selection, target table, ramp and PWM drive.
`timescale 1ns/1ps
module fasc_top #(
    parameter int RampTickCycles = fasc_pkg::RAMP_TICK_CYC,
    parameter int FastPeriod = fasc_pkg::PWM_FAST_CYC,
    parameter int SlowPeriod = fasc_pkg::PWM_SLOW_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic [7:0] tempPlatform,
    input wire logic [7:0] temp1,
    input wire logic [7:0] temp2,
    input wire logic [7:0] temp3,
    input wire logic [7:0] tempCpu,
    input wire logic [7:0] tempPch,
    input wire logic [7:0] tempMch,
    input wire logic [7:0] tempChipMax,
    input wire logic anyOverLimit,
    output logic [7:0] fanDuty,
    output logic fanPwm
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] seg1;
        logic [7:0] seg2;
        logic [7:0] seg3;
        logic [7:0] mapping;
        logic [7:0] ctrl;
        logic [7:0] boundHigh;
        logic [7:0] boundLow;
        logic [7:0] hyst;
        logic aboveHigh;
        logic [7:0] duty;
        logic [31:0] tickCnt;
        logic [7:0] rateCnt;
        logic [7:0] rdData;
    } fasc_state_t;

    fasc_state_t r;
    fasc_state_t next_r;

    // Naming the duty move keeps the priority decision apart from the value that it produces.
    typedef enum logic [2:0] {
        FASC_MOVE_HOLD,
        FASC_MOVE_FULL,
        FASC_MOVE_JUMP_UP,
        FASC_MOVE_JUMP_DOWN,
        FASC_MOVE_FOLLOW,
        FASC_MOVE_RAMP_UP,
        FASC_MOVE_RAMP_DOWN
    } fasc_move_t;

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Relative speed byte to duty: X% of 255 equals 255*32/(V+32), so V of zero gives full duty.
    function automatic logic [7:0] fasc_rel_to_duty(input logic [7:0] v);
        logic [12:0] q;
        q = fasc_pkg::REL_NUMERATOR / 13'({1'b0, v} + fasc_pkg::REL_OFFSET);
        return q[7:0];
    endfunction

    // Picks the controlling temperature from the three-bit source code.
    function automatic logic [7:0] fasc_pick_temp(input logic [2:0] code, input logic [63:0] temps);
        logic [7:0] t;
        case (code)
            3'd0: begin
                t = temps[7:0];
            end
            3'd1: begin
                t = temps[15:8];
            end
            3'd2: begin
                t = temps[23:16];
            end
            3'd3: begin
                t = temps[31:24];
            end
            3'd4: begin
                t = temps[39:32];
            end
            3'd5: begin
                t = temps[47:40];
            end
            3'd6: begin
                t = temps[55:48];
            end
            default: begin
                t = temps[63:56];
            end
        endcase
        return t;
    endfunction

    // Blends from the lower entry to the upper one over a fixed span just below the boundary.
    // A fixed power-of-two span keeps this a shift instead of a divider.
    function automatic logic [7:0] fasc_interp(input logic [7:0] lower, input logic [7:0] upper,
                                               input logic [7:0] t, input logic [7:0] bound,
                                               input logic en);
        logic [8:0] start;
        logic [2:0] frac;
        logic signed [10:0] diff;
        logic signed [13:0] scaled;
        logic signed [10:0] res;
        start = {1'b0, bound} - {1'b0, fasc_pkg::INTERP_SPAN};
        frac = 3'(({1'b0, t} - start));
        diff = 11'(signed'({3'b000, upper})) - 11'(signed'({3'b000, lower}));
        scaled = 14'(diff) * 14'(signed'({11'b0, frac}));
        res = 11'(signed'({3'b000, lower})) + 11'(scaled >>> fasc_pkg::INTERP_SHIFT);
        if (t >= bound) begin
            return upper;
        end else if (!en || start[8] || {1'b0, t} < start) begin
            return lower;
        end else begin
            return res[7:0];
        end
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    logic [2:0] srcCode;
    logic [7:0] ctlTemp;
    logic [1:0] mode;
    logic [1:0] rate;
    logic dutyMode;
    logic [8:0] lowThresh;
    logic [7:0] tableVal;
    logic [7:0] targetDuty;
    logic tick;
    logic rampStep;
    logic [7:0] rateLimit;
    fasc_move_t move;

    always_comb begin
        next_r = r;
        srcCode = {r.mapping[fasc_pkg::MAP_SRC_UPPER], r.mapping[fasc_pkg::MAP_SRC_LO +: 2]};
        ctlTemp = fasc_pick_temp(srcCode, {tempChipMax, tempMch, tempPch, tempCpu,
                                           temp3, temp2, temp1, tempPlatform});
        mode = r.ctrl[fasc_pkg::CTRL_MODE_LO +: 2];
        rate = r.ctrl[fasc_pkg::CTRL_RATE_LO +: 2];
        dutyMode = mode != fasc_pkg::MODE_SPEED;
        lowThresh = {1'b0, r.boundHigh} - {1'b0, r.hyst};

        // Register writes.
        if (regWr) begin
            case (regAddr)
                fasc_pkg::OFF_SEG1: begin
                    next_r.seg1 = regWrData;
                end
                fasc_pkg::OFF_SEG2: begin
                    next_r.seg2 = regWrData;
                end
                fasc_pkg::OFF_SEG3: begin
                    next_r.seg3 = regWrData;
                end
                fasc_pkg::OFF_MAP: begin
                    next_r.mapping = regWrData;
                end
                fasc_pkg::OFF_CTRL: begin
                    next_r.ctrl = {4'h_0, regWrData[3:0]};
                end
                fasc_pkg::OFF_BOUND_HIGH: begin
                    next_r.boundHigh = regWrData;
                end
                fasc_pkg::OFF_BOUND_LOW: begin
                    next_r.boundLow = regWrData;
                end
                fasc_pkg::OFF_HYST: begin
                    next_r.hyst = regWrData;
                end
                default: begin
                end
            endcase
        end

        // Read data stands for exactly one cycle; unmapped addresses read zero.
        next_r.rdData = 8'h_00;
        if (regRd) begin
            case (regAddr)
                fasc_pkg::OFF_SEG1: begin
                    next_r.rdData = r.seg1;
                end
                fasc_pkg::OFF_SEG2: begin
                    next_r.rdData = r.seg2;
                end
                fasc_pkg::OFF_SEG3: begin
                    next_r.rdData = r.seg3;
                end
                fasc_pkg::OFF_MAP: begin
                    next_r.rdData = r.mapping;
                end
                fasc_pkg::OFF_CTRL: begin
                    next_r.rdData = r.ctrl;
                end
                fasc_pkg::OFF_BOUND_HIGH: begin
                    next_r.rdData = r.boundHigh;
                end
                fasc_pkg::OFF_BOUND_LOW: begin
                    next_r.rdData = r.boundLow;
                end
                fasc_pkg::OFF_HYST: begin
                    next_r.rdData = r.hyst;
                end
                fasc_pkg::OFF_DUTY: begin
                    next_r.rdData = r.duty;
                end
                fasc_pkg::OFF_TEMP: begin
                    next_r.rdData = ctlTemp;
                end
                default: begin
                    next_r.rdData = 8'h_00;
                end
            endcase
        end

        // Highest boundary with hysteresis on the way down.
        if (ctlTemp > r.boundHigh) begin
            next_r.aboveHigh = 1'b1;
        end else if (!lowThresh[8] && {1'b0, ctlTemp} < lowThresh) begin
            next_r.aboveHigh = 1'b0;
        end

        // Table lookup: segment one above the top boundary, else segment two or three.
        if (next_r.aboveHigh) begin
            tableVal = r.seg1;
        end else begin
            tableVal = fasc_interp(r.seg3, r.seg2, ctlTemp, r.boundLow,
                                   r.mapping[fasc_pkg::MAP_INTERP]);
        end
        if (mode == fasc_pkg::MODE_SPEED) begin
            targetDuty = fasc_rel_to_duty(tableVal);
        end else begin
            targetDuty = tableVal;
        end

        // Ramp timing: one base tick, then 2^rate ticks per duty step.
        tick = r.tickCnt >= 32'(RampTickCycles - 1);
        next_r.tickCnt = tick ? 32'd0 : r.tickCnt + 32'd1;
        rateLimit = 8'((9'd1 << rate) - 9'd1);
        rampStep = 1'b0;
        if (tick) begin
            if (r.rateCnt >= rateLimit) begin
                next_r.rateCnt = 8'h_00;
                rampStep = 1'b1;
            end else begin
                next_r.rateCnt = r.rateCnt + 8'd1;
            end
        end

        // Duty movement, highest priority first.
        move = FASC_MOVE_HOLD;
        if (anyOverLimit && r.mapping[fasc_pkg::MAP_OVERTEMP]) begin
            move = FASC_MOVE_FULL;
        end else if (dutyMode && next_r.aboveHigh && !r.aboveHigh && r.mapping[fasc_pkg::MAP_STEP_UP]) begin
            move = FASC_MOVE_JUMP_UP;
        end else if (dutyMode && !next_r.aboveHigh && r.aboveHigh && r.mapping[fasc_pkg::MAP_STEP_DOWN]) begin
            move = FASC_MOVE_JUMP_DOWN;
        end else if (!dutyMode) begin
            move = FASC_MOVE_FOLLOW;
        end else if (rampStep && r.duty < targetDuty) begin
            move = FASC_MOVE_RAMP_UP;
        end else if (rampStep && r.duty > targetDuty) begin
            move = FASC_MOVE_RAMP_DOWN;
        end
        case (move)
            FASC_MOVE_FULL: begin
                next_r.duty = fasc_pkg::DUTY_FULL;
            end
            FASC_MOVE_JUMP_UP: begin
                next_r.duty = r.seg1;
            end
            FASC_MOVE_JUMP_DOWN: begin
                next_r.duty = r.seg2;
            end
            FASC_MOVE_FOLLOW: begin
                next_r.duty = targetDuty;
            end
            FASC_MOVE_RAMP_UP: begin
                next_r.duty = r.duty + 8'd1;
            end
            FASC_MOVE_RAMP_DOWN: begin
                next_r.duty = r.duty - 8'd1;
            end
            default: begin
                next_r.duty = r.duty;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '{seg1: fasc_pkg::RST_SEG1,
                   seg2: fasc_pkg::RST_SEG2,
                   seg3: fasc_pkg::RST_SEG3,
                   mapping: fasc_pkg::RST_MAP,
                   ctrl: fasc_pkg::RST_CTRL,
                   boundHigh: fasc_pkg::RST_BOUND_HIGH,
                   boundLow: fasc_pkg::RST_BOUND_LOW,
                   hyst: fasc_pkg::RST_HYST,
                   aboveHigh: 1'b0,
                   duty: 8'h_00,
                   tickCnt: 32'd0,
                   rateCnt: 8'h_00,
                   rdData: 8'h_00};
        end else begin
            r <= next_r;
        end
    end

    assign regRdData = r.rdData;
    assign fanDuty = r.duty;

    // ************************************************************
    // PWM output
    // ************************************************************
    fasc_pwm_gen #(
        .FastPeriod(FastPeriod),
        .SlowPeriod(SlowPeriod)
    ) u_pwm (
        .mclk(mclk),
        .rst(rst),
        .slowSel(r.mapping[fasc_pkg::MAP_FREQ]),
        .duty(r.duty),
        .pwmOut(fanPwm)
    );

endmodule

// ===== hw/fasc_pkg.sv
// Package with register map, reset values, field positions and timing for the fan 3 automatic speed block.
package fasc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFF_SEG1 = 8'h_C0;
    localparam logic [7:0] OFF_SEG2 = 8'h_CB;
    localparam logic [7:0] OFF_SEG3 = 8'h_CE;
    localparam logic [7:0] OFF_MAP = 8'h_CF;
    localparam logic [7:0] OFF_CTRL = 8'h_C1;
    localparam logic [7:0] OFF_BOUND_HIGH = 8'h_C2;
    localparam logic [7:0] OFF_BOUND_LOW = 8'h_C3;
    localparam logic [7:0] OFF_HYST = 8'h_C4;
    localparam logic [7:0] OFF_DUTY = 8'h_C5;
    localparam logic [7:0] OFF_TEMP = 8'h_C6;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_SEG1 = 8'h_FF;
    localparam logic [7:0] RST_SEG2 = 8'h_D9;
    localparam logic [7:0] RST_SEG3 = 8'h_80;
    localparam logic [7:0] RST_MAP = 8'h_1F;
    localparam logic [7:0] RST_CTRL = 8'h_01;
    localparam logic [7:0] RST_BOUND_HIGH = 8'h_46;
    localparam logic [7:0] RST_BOUND_LOW = 8'h_32;
    localparam logic [7:0] RST_HYST = 8'h_04;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int MAP_SRC_UPPER = 7;
    localparam int MAP_FREQ = 6;
    localparam int MAP_OVERTEMP = 5;
    localparam int MAP_INTERP = 4;
    localparam int MAP_STEP_UP = 3;
    localparam int MAP_STEP_DOWN = 2;
    localparam int MAP_SRC_LO = 0;
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_RATE_LO = 2;

    localparam logic [1:0] MODE_SPEED = 2'h_0;
    localparam logic [1:0] MODE_DUTY = 2'h_1;

    localparam logic [7:0] DUTY_FULL = 8'h_FF;
    localparam logic [12:0] REL_NUMERATOR = 13'h_1FE0;
    localparam logic [8:0] REL_OFFSET = 9'h_020;
    localparam logic [7:0] INTERP_SPAN = 8'h_08;
    localparam int INTERP_SHIFT = 3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int PWM_FAST_HZ = 23_500;
    localparam int PWM_SLOW_HZ = 220;
    localparam int PWM_FAST_CYC = CLK_HZ / PWM_FAST_HZ;
    localparam int PWM_SLOW_CYC = CLK_HZ / PWM_SLOW_HZ;
    localparam int RAMP_TICK_US = 100;
    localparam int RAMP_TICK_CYC = RAMP_TICK_US * (CLK_HZ / 1_000_000);

endpackage

// ===== hw/fasc_pwm_gen.sv
// PWM generator that turns an 8-bit duty into a fan output at one of two frequencies.
`timescale 1ns/1ps
module fasc_pwm_gen #(
    parameter int FastPeriod = fasc_pkg::PWM_FAST_CYC,
    parameter int SlowPeriod = fasc_pkg::PWM_SLOW_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic slowSel,
    input wire logic [7:0] duty,
    output logic pwmOut
);

    typedef struct packed {
        logic [19:0] cnt;
        logic [19:0] period;
        logic [19:0] highLen;
        logic out;
    } fasc_pwm_state_t;

    fasc_pwm_state_t r;
    fasc_pwm_state_t next_r;
    logic [19:0] selPeriod;
    logic [27:0] product;

    // Duty and frequency are taken only at a period boundary so the output never glitches.
    always_comb begin
        next_r = r;
        selPeriod = slowSel ? 20'(SlowPeriod) : 20'(FastPeriod);
        product = 28'(duty) * 28'(selPeriod);
        if (r.cnt >= r.period - 20'd1) begin
            next_r.cnt = '0;
            next_r.period = selPeriod;
            next_r.highLen = 20'(product / 28'd255);
        end else begin
            next_r.cnt = r.cnt + 20'd1;
        end
        next_r.out = next_r.cnt < next_r.highLen;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '{cnt: '0, period: 20'(FastPeriod), highLen: '0, out: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign pwmOut = r.out;

endmodule

// ===== tb/fasc_fan_model.sv
// Fan model that measures the high time and the period of the PWM drive.
`timescale 1ns/1ps
module fasc_fan_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic fanPwm,
    output logic [19:0] highLen,
    output logic [19:0] perLen
);
    logic prevPwm;
    logic [19:0] highRun;
    logic [19:0] perRun;
    // A period is counted from one rising edge to the next, so a steady level shows no new period.
    always_ff @(posedge mclk) begin
        prevPwm <= fanPwm;
        if (rst) begin
            highRun <= '0;
            perRun <= '0;
            highLen <= '0;
            perLen <= '0;
        end else if (fanPwm && !prevPwm) begin
            highLen <= highRun;
            perLen <= perRun;
            highRun <= 20'h_0001;
            perRun <= 20'h_0001;
        end else begin
            perRun <= perRun + 20'h_0001;
            highRun <= highRun + 20'(fanPwm);
        end
    end
endmodule

// ===== tb/fasc_top_chk.sv
// Port checker of the fan 3 automatic speed block, bound to its top module.
`timescale 1ns/1ps
module fasc_top_chk #(
    parameter int SlowPeriod = fasc_pkg::PWM_SLOW_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic [7:0] tempPlatform,
    input wire logic [7:0] temp1,
    input wire logic [7:0] temp2,
    input wire logic [7:0] temp3,
    input wire logic [7:0] tempCpu,
    input wire logic [7:0] tempPch,
    input wire logic [7:0] tempMch,
    input wire logic [7:0] tempChipMax,
    input wire logic anyOverLimit,
    input wire logic [7:0] fanDuty,
    input wire logic fanPwm
);
    logic [7:0] sh [16];
    logic [7:0] tv [8];
    logic [7:0] selT;
    logic [19:0] zeroRun;
    logic dutyMode, quiet, hiT, midT, coldT;
    // Shadow indexed by the low address nibble; entries of read-only or unmapped places are never used.
    always_ff @(posedge mclk) begin
        if (rst) begin
            sh <= '{4'h0: fasc_pkg::RST_SEG1, 4'h1: fasc_pkg::RST_CTRL, 4'h2: fasc_pkg::RST_BOUND_HIGH,
                4'h3: fasc_pkg::RST_BOUND_LOW, 4'h4: fasc_pkg::RST_HYST, 4'hB: fasc_pkg::RST_SEG2,
                4'hE: fasc_pkg::RST_SEG3, 4'hF: fasc_pkg::RST_MAP, default: 8'h_00};
        end else if (regWr && regAddr[7:4] == 4'hC) begin
            sh[regAddr[3:0]] <= regWrData;
        end
        zeroRun <= (rst || fanDuty != 8'h_00) ? 20'h_0000 : zeroRun + 20'h_0001;
    end
    assign tv = '{tempPlatform, temp1, temp2, temp3, tempCpu, tempPch, tempMch, tempChipMax};
    assign selT = tv[{sh[15][7], sh[15][1:0]}];
    assign dutyMode = sh[1][1:0] != fasc_pkg::MODE_SPEED;
    assign quiet = !anyOverLimit && !regWr;
    assign hiT = selT > sh[2];
    assign midT = selT >= sh[3] && ({1'b0, selT} + {1'b0, sh[4]}) < {1'b0, sh[2]};
    assign coldT = ({1'b0, selT} + 9'h_008) < {1'b0, sh[3]};
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    property p_rd_map; regRd && regAddr == fasc_pkg::OFF_MAP |=> regRdData == $past(sh[15]); endproperty
    a_rd_map: assert property (p_rd_map) else $error("mapping readback wrong");
    property p_rd_seg3; regRd && regAddr == fasc_pkg::OFF_SEG3 |=> regRdData == $past(sh[14]); endproperty
    a_rd_seg3: assert property (p_rd_seg3) else $error("segment 3 readback wrong");
    property p_src; regRd && regAddr == fasc_pkg::OFF_TEMP && $stable(selT) |=> regRdData == $past(selT); endproperty
    a_src: assert property (p_src) else $error("selected temperature wrong");
    property p_over; sh[15][5] && anyOverLimit |=> fanDuty == 8'h_FF; endproperty
    a_over: assert property (p_over) else $error("no full speed on over limit");
    property p_pwm_off; zeroRun > 20'(2 * SlowPeriod + 4) |-> !fanPwm; endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("pwm high at zero duty");
    property p_speed; (!dutyMode && coldT && quiet)[*4] |-> fanDuty == 8'(16'h_1FE0 / ({8'h_00, sh[14]} + 16'h_0020)); endproperty
    a_speed: assert property (p_speed) else $error("relative speed duty wrong");
    property p_up; (dutyMode && sh[15][3] && midT && quiet)[*2] ##1 (dutyMode && sh[15][3] && hiT && quiet)[*4] |-> fanDuty == sh[0]; endproperty
    a_up: assert property (p_up) else $error("no jump to segment 1");
    property p_down; (dutyMode && sh[15][2] && hiT && quiet)[*2] ##1 (dutyMode && sh[15][2] && midT && quiet)[*4] |-> fanDuty == sh[11]; endproperty
    a_down: assert property (p_down) else $error("no jump to segment 2");
    c_over: cover property (sh[15][5] && anyOverLimit);
    c_speed: cover property (!dutyMode && coldT);
    c_zero: cover property (zeroRun > 20'(SlowPeriod));
endmodule
bind fasc_top fasc_top_chk #(.SlowPeriod(SlowPeriod)) fasc_top_chk_inst (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .tempPlatform(tempPlatform), .temp1(temp1), .temp2(temp2), .temp3(temp3),
    .tempCpu(tempCpu), .tempPch(tempPch), .tempMch(tempMch), .tempChipMax(tempChipMax),
    .anyOverLimit(anyOverLimit), .fanDuty(fanDuty), .fanPwm(fanPwm));

// ===== tb/tb_fasc_top.sv
// Self-checking testbench of the fan 3 automatic speed block with a fan model.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_fasc_top;
    localparam logic [7:0] AMAP = fasc_pkg::OFF_MAP, ASEG1 = fasc_pkg::OFF_SEG1, ASEG3 = fasc_pkg::OFF_SEG3;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h_00;
    logic [7:0] regWrData = 8'h_00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic anyOverLimit = 1'b0;
    logic [7:0] temps [8];
    logic [7:0] regRdData, fanDuty;
    logic fanPwm;
    logic [19:0] highLen, perLen;
    int error_cnt = 0;
    int cmp_count = 0;
    always #5 mclk = ~mclk;
    // Short PWM periods and ramp tick keep the run brief; expectations below use the same figures.
    fasc_top #(.RampTickCycles(4), .FastPeriod(20), .SlowPeriod(40)) fasc_top_inst (
        .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .tempPlatform(temps[0]), .temp1(temps[1]), .temp2(temps[2]), .temp3(temps[3]),
        .tempCpu(temps[4]), .tempPch(temps[5]), .tempMch(temps[6]), .tempChipMax(temps[7]),
        .anyOverLimit(anyOverLimit), .fanDuty(fanDuty), .fanPwm(fanPwm));
    fasc_fan_model fasc_fan_model_inst (.mclk(mclk), .rst(rst), .fanPwm(fanPwm), .highLen(highLen), .perLen(perLen));
    function automatic logic [7:0] spd(input logic [7:0] v);
        return 8'(16'h_1FE0 / ({8'h_00, v} + 16'h_0020));
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        `CHK(regRdData, e)
    endtask
    task automatic setT(input logic [7:0] t, input int n);
        @(posedge mclk);
        temps[1] <= t;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chkd(input logic [7:0] e);
        #1;
        `CHK(fanDuty, e)
    endtask
    task automatic done(input string n);
        $display("test %s finished, mismatches %0d", n, error_cnt);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #900_000;
        error_cnt++;
        report_and_stop;
    end
    initial begin
        logic [7:0] v;
        void'($urandom(32'h_f890));
        foreach (temps[i]) temps[i] = 8'($urandom);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rdc(ASEG3, 8'h_80);
        rdc(AMAP, fasc_pkg::RST_MAP);
        rdc(fasc_pkg::OFF_TEMP, temps[3]);
        rdc(8'h_55, 8'h_00);
        for (int c = 0; c < 8; c++) begin
            v = 8'h_1C | {c[2], 5'h_00, c[1:0]};
            wr(AMAP, v);
            rdc(AMAP, v);
            rdc(fasc_pkg::OFF_TEMP, temps[c]);
        end
        v = 8'($urandom);
        wr(ASEG3, v);
        rdc(ASEG3, v);
        done("registers");
        wr(AMAP, 8'h_1D);
        v = 8'($urandom_range(254, 1));
        wr(ASEG1, v);
        wr(fasc_pkg::OFF_SEG2, 8'h_00);
        setT(8'h_3C, 8);
        setT(8'h_50, 7);
        chkd(v);
        setT(8'h_3C, 100);
        chkd(8'h_00);
        `CHK(fanPwm, 1'b0)
        wr(AMAP, 8'h_15);
        wr(ASEG1, 8'h_10);
        setT(8'h_50, 3);
        `CHK(fanDuty <= 8'h_01, 1'b1)
        for (int i = 0; i < 400 && fanDuty !== 8'h_10; i++) begin
            @(posedge mclk);
            #1;
        end
        chkd(8'h_10);
        wr(AMAP, 8'h_11);
        setT(8'h_3C, 3);
        `CHK(fanDuty >= 8'h_0F, 1'b1)
        done("step");
        @(posedge mclk);
        anyOverLimit <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK(fanDuty <= 8'h_10, 1'b1)
        `CHK(fanDuty === 8'h_FF, 1'b0)
        wr(AMAP, 8'h_31);
        repeat (2) @(posedge mclk);
        chkd(8'h_FF);
        @(posedge mclk);
        anyOverLimit <= 1'b0;
        wr(AMAP, 8'h_1D);
        wr(ASEG1, 8'h_80);
        setT(8'h_50, 70);
        `CHK(perLen, 20'(20))
        `CHK(highLen, 20'(128 * 20 / 255))
        wr(AMAP, 8'h_5D);
        repeat (130) @(posedge mclk);
        #1;
        `CHK(perLen, 20'(40))
        `CHK(highLen, 20'(128 * 40 / 255))
        done("overtemp and pwm");
        wr(fasc_pkg::OFF_CTRL, 8'h_00);
        wr(AMAP, 8'h_0D);
        setT(8'h_20, 2);
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'h_00 : (i == 1) ? 8'h_15 : 8'($urandom);
            wr(ASEG3, v);
            repeat (6) @(posedge mclk);
            chkd(spd(v));
        end
        setT(8'h_2E, 6);
        chkd(spd(v));
        wr(AMAP, 8'h_1D);
        repeat (6) @(posedge mclk);
        chkd(spd(v >> 1));
        done("speed");
        report_and_stop;
    end
endmodule
